// ===== hdl/scbr_top.sv
// module: register bank with command, burst and firmware ports
`timescale 1ns/1ps
module scbr_top
  import scbr_pkg::*;
(
  // system
  input wire logic CLK,
  input wire logic RESET,
  input wire logic CE,
  // spi link
  input wire logic SCLK,
  input wire logic NCS,
  input wire logic MOSI,
  output logic MISO,
  // navigation core
  input wire scbr_pkg::scbr_motion_t MOTION_IN,
  input wire logic MOTION_VALID,
  input wire logic [7:0] PIXEL_IN,
  output logic [9:0] PIXEL_ADDR,
  // firmware store
  output logic FW_WE,
  output logic [11:0] FW_ADDR,
  output logic [7:0] FW_DATA,
  output logic FW_SIZE,
  // state
  output logic SHUTDOWN,
  output logic CHIP_RESET
);
  import scbr_pkg::*;

  scbr_xfer_t xfer;
  logic xfer_tgl;
  logic [7:0] rd_byte;
  logic rd_tgl;
  logic tgl_s;
  logic tgl_d;
  logic soft_rst;
  logic [7:0] config_iv;
  logic [3:0] burst_idx;
  logic [9:0] pix_ptr;
  logic [11:0] fw_cnt;
  scbr_motion_t snap;
  logic [7:0] next_rd;
  logic ev;

  scbr_spi_link u_link (
    .sclk(SCLK),
    .ncs(NCS),
    .mosi(MOSI),
    .miso(MISO),
    .xfer(xfer),
    .xfer_tgl(xfer_tgl),
    .rd_data(rd_byte),
    .rd_tgl(rd_tgl)
  );

  scbr_sync #(.W(1)) u_sync (
    .clk(CLK),
    .d(xfer_tgl),
    .q(tgl_s)
  );

  // toggle edge marks a transaction; xfer is stable by then
  always_ff @(posedge CLK) begin
    if (RESET)
      tgl_d <= 1'b0;
    else if (CE)
      tgl_d <= tgl_s;
  end
  assign ev = CE && (tgl_s != tgl_d);
  logic wr_ev;
  logic rd_ev;
  assign wr_ev = ev && xfer.write;
  assign rd_ev = ev && !xfer.write;

  always_ff @(posedge CLK) begin
    if (RESET)
      soft_rst <= 1'b0;
    else if (CE)
      soft_rst <= wr_ev && xfer.addr == ADDR_CHIP_RESET
        && xfer.data == CMD_CHIP_RESET;
  end
  assign CHIP_RESET = soft_rst;

  // shutdown entry; left only by chip reset or RESET
  always_ff @(posedge CLK) begin
    if (RESET || (CE && soft_rst))
      SHUTDOWN <= 1'b0;
    else if (wr_ev && xfer.addr == ADDR_SHUTDOWN
             && xfer.data == CMD_SHUTDOWN)
      SHUTDOWN <= 1'b1;
  end

  // settings default on reset; size bit
  always_ff @(posedge CLK) begin
    if (RESET || (CE && soft_rst))
      config_iv <= CONFIG_IV_RST;
    else if (wr_ev && xfer.addr == ADDR_CONFIG_IV)
      config_iv <= xfer.data & (8'h01 << FW_SIZE_BIT);
  end
  assign FW_SIZE = config_iv[FW_SIZE_BIT];

  // write clears burst data; snapshot taken from core
  always_ff @(posedge CLK) begin
    if (RESET || (CE && soft_rst))
      snap <= '0;
    else if (wr_ev && xfer.addr == ADDR_MOVE_BURST)
      snap <= '0;
    else if (CE && MOTION_VALID && burst_idx == 4'h0)
      snap <= MOTION_IN;
  end

  always_ff @(posedge CLK) begin
    if (RESET || (CE && soft_rst))
      burst_idx <= 4'h0;
    else if (wr_ev && xfer.addr == ADDR_MOVE_BURST)
      burst_idx <= 4'h0;
    else if (rd_ev && xfer.addr == ADDR_MOVE_BURST)
      burst_idx <= (burst_idx == 4'(BURST_LEN - 1)) ? 4'h0
                   : burst_idx + 4'h1;
  end

  // pixel pointer advances per dump read
  always_ff @(posedge CLK) begin
    if (RESET || (CE && soft_rst))
      pix_ptr <= 10'h000;
    else if (rd_ev && xfer.addr == ADDR_IMG_DUMP)
      pix_ptr <= (pix_ptr == 10'(PIXEL_COUNT - 1)) ? 10'h000
                 : pix_ptr + 10'h001;
  end
  assign PIXEL_ADDR = pix_ptr;

  // firmware stream into store, address wraps at chosen size
  always_ff @(posedge CLK) begin
    if (RESET || (CE && soft_rst)) begin
      fw_cnt <= 12'h000;
      FW_WE <= 1'b0;
      FW_ADDR <= 12'h000;
      FW_DATA <= 8'h00;
    end else if (CE) begin
      FW_WE <= wr_ev && xfer.addr == ADDR_FW_LOAD;
      if (wr_ev && xfer.addr == ADDR_FW_LOAD) begin
        FW_ADDR <= fw_cnt;
        FW_DATA <= xfer.data;
        if (fw_cnt == (FW_SIZE ? 12'(FW_LARGE_BYTES - 1)
                               : 12'(FW_SMALL_BYTES - 1)))
          fw_cnt <= 12'h000;
        else
          fw_cnt <= fw_cnt + 12'h001;
      end
    end
  end

  // read mux; inverse part code; pixel stream
  always_comb begin
    next_rd = 8'h00;
    case (xfer.addr)
      ADDR_PART_CODE: next_rd = PART_CODE_VAL;
      ADDR_INV_PART: next_rd = ~PART_CODE_VAL;
      ADDR_CONFIG_IV: next_rd = config_iv;
      ADDR_IMG_DUMP: next_rd = PIXEL_IN;
      ADDR_MOVE_BURST: begin
        case (burst_idx)
          4'h0: next_rd = snap.motion;
          4'h1: next_rd = snap.observation;
          4'h2: next_rd = snap.dx[7:0];
          4'h3: next_rd = snap.dx[15:8];
          4'h4: next_rd = snap.dy[7:0];
          4'h5: next_rd = snap.dy[15:8];
          4'h6: next_rd = snap.surface_quality;
          4'h7: next_rd = snap.pix_sum;
          4'h8: next_rd = snap.pix_max;
          4'h9: next_rd = snap.pix_min;
          4'hA: next_rd = snap.shutter[15:8];
          4'hB: next_rd = snap.shutter[7:0];
          4'hC: next_rd = snap.frame_period[15:8];
          4'hD: next_rd = snap.frame_period[7:0];
          default: next_rd = 8'h00;
        endcase
      end
      default: next_rd = 8'h00;
    endcase
  end

  // answer byte captured on the read event; held stable for the link
  always_ff @(posedge CLK) begin
    if (RESET) begin
      rd_byte <= 8'h00;
      rd_tgl <= 1'b0;
    end else if (rd_ev) begin
      rd_byte <= next_rd;
      rd_tgl <= ~rd_tgl;
    end
  end
endmodule

// ===== hdl/scbr_pkg.sv
// package: register map, command codes and shared types of the sensor block
package scbr_pkg;
  localparam logic [6:0] ADDR_PART_CODE = 7'h00;
  localparam logic [6:0] ADDR_CONFIG_IV = 7'h39;
  localparam logic [6:0] ADDR_CHIP_RESET = 7'h3A;
  localparam logic [6:0] ADDR_SHUTDOWN = 7'h3B;
  localparam logic [6:0] ADDR_INV_PART = 7'h3F;
  localparam logic [6:0] ADDR_MOVE_BURST = 7'h50;
  localparam logic [6:0] ADDR_FW_LOAD = 7'h62;
  localparam logic [6:0] ADDR_IMG_DUMP = 7'h64;
  localparam logic [7:0] CMD_CHIP_RESET = 8'h5A;
  localparam logic [7:0] CMD_SHUTDOWN = 8'hB6;
  // arbitrary neutral identity value
  localparam logic [7:0] PART_CODE_VAL = 8'h5C;
  localparam logic [7:0] CONFIG_IV_RST = 8'h00;
  localparam int FW_SIZE_BIT = 1;
  localparam int BURST_LEN = 14;
  localparam int PIXEL_COUNT = 900;
  localparam int FW_SMALL_BYTES = 1536;
  localparam int FW_LARGE_BYTES = 3072;
  localparam int SPI_BITS = 8;

  // one byte transaction decoded on the link side
  typedef struct packed {
    logic write;
    logic [6:0] addr;
    logic [7:0] data;
  } scbr_xfer_t;

  // motion snapshot fed by the navigation core
  typedef struct packed {
    logic [7:0] motion;
    logic [7:0] observation;
    logic [15:0] dx;
    logic [15:0] dy;
    logic [7:0] surface_quality;
    logic [7:0] pix_sum;
    logic [7:0] pix_max;
    logic [7:0] pix_min;
    logic [15:0] shutter;
    logic [15:0] frame_period;
  } scbr_motion_t;
endpackage

// ===== hdl/scbr_sync.sv
// module: two-flop level synchroniser, one per bit
`timescale 1ns/1ps
module scbr_sync #(
  parameter int W = 1
) (
  // clock and data
  input wire logic clk,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  // first stage is read only by the second
  always_ff @(posedge clk) begin
    meta <= d;
    q <= meta;
  end
endmodule

// ===== hdl/scbr_spi_link.sv
// module: spi slave on the link clock, exchanges transactions by toggle
`timescale 1ns/1ps
module scbr_spi_link
  import scbr_pkg::*;
(
  // link side
  input wire logic sclk,
  input wire logic ncs,
  input wire logic mosi,
  output logic miso,
  // handshake toward system clock
  output scbr_xfer_t xfer,
  output logic xfer_tgl,
  input wire logic [7:0] rd_data,
  input wire logic rd_tgl
);
  logic [2:0] bit_cnt;
  logic phase_data;
  logic [7:0] shift;
  logic [7:0] tx;
  logic [6:0] addr;
  logic wr;

  // receive on rising edge; address byte then data bytes, address kept
  // so burst ports stream without re-addressing; frame reset by ncs
  always_ff @(posedge sclk or posedge ncs) begin
    if (ncs) begin
      bit_cnt <= 3'h0;
      phase_data <= 1'b0;
      shift <= 8'h00;
      addr <= 7'h00;
      wr <= 1'b0;
      xfer_tgl <= 1'b0;
      xfer <= '0;
    end else begin
      shift <= {shift[6:0], mosi};
      bit_cnt <= bit_cnt + 3'h1;
      if (bit_cnt == 3'h7) begin
        phase_data <= 1'b1;
        if (!phase_data) begin
          wr <= shift[6];
          addr <= {shift[5:0], mosi};
          xfer <= '{write: shift[6], addr: {shift[5:0], mosi}, data: 8'h00};
          // reads announce themselves after the address byte
          if (!shift[6])
            xfer_tgl <= ~xfer_tgl;
        end else begin
          xfer <= '{write: wr, addr: addr, data: {shift[6:0], mosi}};
          xfer_tgl <= ~xfer_tgl;
        end
      end
    end
  end

  // answer byte is loaded when returned; limitation: controller must
  // wait a few system clocks between address and data bytes
  always_ff @(negedge sclk or posedge ncs) begin
    if (ncs) begin
      tx <= 8'h00;
      miso <= 1'b0;
    end else begin
      if (bit_cnt == 3'h0 && phase_data) begin
        miso <= rd_data[7];
        tx <= {rd_data[6:0], 1'b0};
      end else begin
        miso <= tx[7];
        tx <= {tx[6:0], 1'b0};
      end
    end
  end

  // rd_tgl unused in this domain; it is only sampled into rd_seen, which nothing reads
  logic rd_seen;
  always_ff @(posedge sclk or posedge ncs) begin
    if (ncs)
      rd_seen <= 1'b0;
    else
      rd_seen <= rd_tgl;
  end
endmodule

// ===== verification/scbr_checker.sv
// checker: port-level properties of the sensor register bank
`timescale 1ns/1ps
module scbr_checker (
  // clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // watched outputs
  input wire logic [9:0] PIXEL_ADDR,
  input wire logic FW_WE,
  input wire logic [11:0] FW_ADDR,
  input wire logic FW_SIZE,
  input wire logic SHUTDOWN,
  input wire logic CHIP_RESET
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  logic [11:0] fw_prev;
  logic fw_any;
  // remember the last firmware address, steps are judged against it
  always_ff @(posedge CLK) begin
    if (RESET) fw_any <= 1'b0;
    else if (FW_WE) fw_any <= 1'b1;
  end
  always_ff @(posedge CLK) begin
    if (FW_WE) fw_prev <= FW_ADDR;
  end
  AST_RESET_PULSE: assert property (CHIP_RESET |=> !CHIP_RESET)
    else $error("chip reset pulse too long");
  AST_RESET_WAKES: assert property (
    CHIP_RESET |-> ##[0:2] !SHUTDOWN) else $error("reset kept shutdown");
  AST_SHUT_HOLDS: assert property ($fell(SHUTDOWN) |->
    CHIP_RESET || $past(CHIP_RESET) || $past(CHIP_RESET, 2))
    else $error("shutdown left without reset");
  AST_RESET_DEFAULTS: assert property (CHIP_RESET |->
    ##[0:2] (PIXEL_ADDR == 10'h000 && !FW_SIZE))
    else $error("settings kept after reset");
  AST_RESET_CLEARS: assert property (disable iff (1'b0)
    RESET |=> !SHUTDOWN && !CHIP_RESET && !FW_WE)
    else $error("outputs not cleared by reset");
  AST_FW_PULSE: assert property (FW_WE |=> !FW_WE)
    else $error("firmware strobe too long");
  AST_FW_STEP: assert property (FW_WE && fw_any |->
    FW_ADDR == fw_prev + 12'h001 || FW_ADDR == 12'h000)
    else $error("firmware address skipped");
  AST_FW_BOUND: assert property (FW_WE |->
    FW_ADDR < (FW_SIZE ? 12'hC00 : 12'h600))
    else $error("firmware address beyond size");
  AST_PIX_RANGE: assert property (PIXEL_ADDR <= 10'h383)
    else $error("pixel pointer beyond frame");
  AST_PIX_STEP: assert property ($changed(PIXEL_ADDR) |->
    PIXEL_ADDR == $past(PIXEL_ADDR) + 10'h001 || PIXEL_ADDR == 10'h000)
    else $error("pixel pointer jumped");
endmodule
bind scbr_top scbr_checker i_chk (
  .CLK(CLK), .RESET(RESET), .PIXEL_ADDR(PIXEL_ADDR), .FW_WE(FW_WE),
  .FW_ADDR(FW_ADDR), .FW_SIZE(FW_SIZE), .SHUTDOWN(SHUTDOWN),
  .CHIP_RESET(CHIP_RESET));

// ===== verification/scbr_master.sv
// partner: microcontroller side of the four-wire link
`timescale 1ns/1ps
module scbr_master (
  // link
  output logic sclk,
  output logic ncs,
  output logic mosi,
  input wire logic miso
);
  // link idles high and deselected; clock stands still between frames
  initial begin
    sclk = 1'b1;
    ncs = 1'b1;
    mosi = 1'b0;
  end
  // one byte, msb first; gap after it lets the device fetch read data
  task automatic shift(input logic [7:0] d, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      sclk = 1'b0;
      mosi = d[i];
      #80;
      sclk = 1'b1;
      r[i] = miso;
      #80;
    end
    #200;
  endtask
  task automatic open_frame(input logic w, input logic [6:0] a);
    logic [7:0] r;
    ncs = 1'b0;
    #113;
    shift({w, a}, r);
  endtask
  // released data line shows the inverse, never the last bit
  task automatic close_frame();
    #100;
    ncs = 1'b1;
    mosi = ~mosi;
    #400;
  endtask
endmodule

// ===== verification/tb.sv
// testbench: drives the sensor register bank through the link master
`timescale 1ns/1ps
`define CHK(a, b, m) begin checked++; if ((a) !== (b)) begin err_count++; \
  $display("BAD %0t %s", $time, m); end end
module tb;
  import scbr_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic sclk, ncs, mosi, miso, fw_we, fw_size, shutdown, chip_reset;
  logic [9:0] pixel_addr;
  logic [11:0] fw_addr;
  logic [7:0] fw_data;
  logic [7:0] fw_last;
  scbr_motion_t mo = 112'h8011_2233_4455_6677_8899_AABB_CCDD;
  wire logic [7:0] pixel_in = pixel_addr[7:0] ^ 8'h3C;
  int err_count, checked, cr_seen, fw_cnt, cycles;
  scbr_top i_dut (.CLK(clk), .RESET(reset), .CE(1'b1), .SCLK(sclk),
    .NCS(ncs), .MOSI(mosi), .MISO(miso), .MOTION_IN(mo),
    .MOTION_VALID(1'b1), .PIXEL_IN(pixel_in), .PIXEL_ADDR(pixel_addr),
    .FW_WE(fw_we), .FW_ADDR(fw_addr), .FW_DATA(fw_data),
    .FW_SIZE(fw_size), .SHUTDOWN(shutdown), .CHIP_RESET(chip_reset));
  scbr_master i_mst (.sclk(sclk), .ncs(ncs), .mosi(mosi), .miso(miso));
  // 50 MHz system clock
  always #10 clk = ~clk;
  // pulse monitor and hang guard; the pixel dump dominates run time
  always @(posedge clk) begin
    cycles++;
    if (chip_reset === 1'b1) cr_seen++;
    if (fw_we === 1'b1) begin
      fw_cnt++;
      fw_last = fw_data;
    end
    if (cycles == 90000) begin
      err_count++;
      close_out();
    end
  end
  task automatic close_out();
    if (err_count == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] r;
    i_mst.open_frame(1'b1, a);
    i_mst.shift(d, r);
    i_mst.close_frame();
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] r);
    i_mst.open_frame(1'b0, a);
    i_mst.shift(8'h00, r);
    i_mst.close_frame();
  endtask
  task automatic t_ident();
    logic [7:0] r;
    rd(ADDR_INV_PART, r);
    `CHK(r, ~PART_CODE_VAL, "inverse code")
    rd(ADDR_SHUTDOWN, r);
    `CHK(r, 8'h00, "shutdown read")
    rd(ADDR_CHIP_RESET, r);
    `CHK(r, 8'h00, "reset read")
  endtask
  task automatic t_shut();
    int n;
    wr(ADDR_SHUTDOWN, 8'h55);
    `CHK(shutdown, 1'b0, "odd code shut")
    wr(ADDR_SHUTDOWN, CMD_SHUTDOWN);
    `CHK(shutdown, 1'b1, "no shutdown")
    n = cr_seen;
    wr(ADDR_CHIP_RESET, 8'hA5);
    `CHK(shutdown, 1'b1, "odd code woke")
    wr(ADDR_CHIP_RESET, CMD_CHIP_RESET);
    `CHK(cr_seen, n + 1, "reset pulse")
    `CHK(shutdown, 1'b0, "still shut")
  endtask
  task automatic t_burst();
    logic [7:0] r;
    logic [7:0] e [14];
    e = '{mo.motion, mo.observation, mo.dx[7:0], mo.dx[15:8], mo.dy[7:0],
      mo.dy[15:8], mo.surface_quality, mo.pix_sum, mo.pix_max, mo.pix_min,
      mo.shutter[15:8], mo.shutter[7:0], mo.frame_period[15:8],
      mo.frame_period[7:0]};
    wr(ADDR_MOVE_BURST, 8'h77);
    i_mst.open_frame(1'b0, ADDR_MOVE_BURST);
    for (int i = 0; i < BURST_LEN; i++) begin
      i_mst.shift(8'h00, r);
      `CHK(r, e[i], "burst byte")
    end
    i_mst.close_frame();
  endtask
  task automatic t_fw();
    logic [7:0] r;
    int n;
    wr(ADDR_CONFIG_IV, 8'h02);
    `CHK(fw_size, 1'b1, "size bit")
    n = fw_cnt;
    i_mst.open_frame(1'b1, ADDR_FW_LOAD);
    for (int i = 0; i < 3; i++) i_mst.shift(8'hC0 + 8'(i), r);
    i_mst.close_frame();
    `CHK(fw_cnt, n + 3, "firmware bytes")
    `CHK(fw_last, 8'hC2, "firmware data")
  endtask
  task automatic t_pix();
    logic [7:0] r;
    wr(ADDR_CHIP_RESET, CMD_CHIP_RESET);
    `CHK(fw_size, 1'b0, "config kept")
    i_mst.open_frame(1'b0, ADDR_IMG_DUMP);
    for (int i = 0; i <= PIXEL_COUNT; i++) begin
      i_mst.shift(8'h00, r);
      `CHK(r, 8'(i % PIXEL_COUNT) ^ 8'h3C, "pixel")
    end
    i_mst.close_frame();
  endtask
  // reset for 8 cycles, then each scenario in turn
  initial begin
    repeat (8) @(posedge clk);
    #2 reset = 1'b0;
    repeat (4) @(posedge clk);
    t_ident();
    t_shut();
    t_burst();
    t_fw();
    t_pix();
    close_out();
  end
endmodule
